// ### apc_pkg.sv
// constants, encodings and carrier types for the audio path config bank
package apc_pkg;

    localparam int WORD_W = 16;

    // word selectors on the load and readback ports
    localparam logic WSEL_A = 1'b0;
    localparam logic WSEL_B = 1'b1;

    // reset values: AGC, filter and volume stages powered down, aux stage on
    localparam logic [15:0] RST_A = 16'h0001;
    localparam logic [15:0] RST_B = 16'h01E3;

    // field positions in audio_route_config_a
    localparam int A_VOL_PD = 0;
    localparam int A_SPK_LO = 1;
    localparam int A_OUT_LO = 3;
    localparam int A_INSRC = 9;

    // field positions in audio_route_config_b
    localparam int B_AGC_PD = 0;
    localparam int B_FLT_PD = 1;
    localparam int B_RATE_LO = 2;
    localparam int B_FLTSRC = 4;
    localparam int B_MIX2_LO = 5;
    localparam int B_MIX1_LO = 7;
    localparam int B_ATT_LO = 11;
    localparam int B_VSRC_LO = 14;

    // field codes, written hi:lo
    localparam logic [1:0] MIX1_INSRC_ONLY = 2'h2;
    localparam logic [1:0] MIX2_FILT_ONLY = 2'h2;
    localparam logic [1:0] VSRC_SUM2 = 2'h1;
    localparam logic [1:0] OUT_VOLUME = 2'h0;
    localparam logic [1:0] SPK_HIGH_GAIN = 2'h1;
    localparam logic [2:0] ATT_MINUS_12DB = 3'h3;
    localparam logic INSRC_AGC = 1'b0;
    localparam logic FLTSRC_SUM1 = 1'b0;
    localparam logic FLTSRC_ARRAY = 1'b1;

    typedef enum logic [1:0] {
        APC_RATE_8K0 = 2'h0,
        APC_RATE_6K4 = 2'h1,
        APC_RATE_5K3 = 2'h2,
        APC_RATE_4K0 = 2'h3
    } apc_rate_t;

    // one word handed over by the serial receiver
    typedef struct packed {
        logic valid;
        logic sel;
        logic [15:0] data;
    } apc_load_t;

    // decoded routing controls seen by the analog stages
    typedef struct packed {
        logic agc_on;
        logic insrc_is_agc;
        logic mix1_insrc_only;
        logic filt_from_array;
        logic filt_on;
        apc_rate_t rate;
        logic mix2_filt_only;
        logic vol_from_sum2;
        logic vol_on;
        logic [2:0] atten;
        logic att_is_12db;
        logic spk_from_vol;
        logic spk_high_gain;
        logic aux_on;
    } apc_route_t;

endpackage : apc_pkg

// ### apc_cfg_bank.sv
// two configuration words, staged on load and applied at frame end
`timescale 1ns/1ps

// How it works
// (R1) agc_power_down low powers the AGC up
// (R2) input_source_select low picks the AGC
// (R3) first mix code 10 feeds input mux only
// (R4) filter_source_select low takes first sum
// (R5) filter_source_select high takes array playback
// (R6) filter_power_down low powers the filter
// (R7) rate code 10 selects 5.3 kHz
// (R8) rate code 00 selects 8.0 kHz
// (R9) second mix code 10 passes filter only
// (R10) volume source 01 takes second sum
// (R11) volume_power_down low powers the attenuator
// (R12) attenuation field is a binary step count
// (R13) attenuation code 011 means minus 12 dB
// (R14) output select 00 routes volume to speaker
// (R15) speaker mode 01: high gain, aux off
// (R16) host loads word a before word b
// (R17) all staged words apply on select rising
// (R18) a word holds until loaded again
module apc_cfg_bank #(
    parameter int WORD_W = apc_pkg::WORD_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ss_n_in,
    input wire apc_pkg::apc_load_t load_in,
    input wire logic rd_sel_in,
    output logic [15:0] rd_data_out,
    output logic [15:0] cfg_a_out,
    output logic [15:0] cfg_b_out,
    output logic applied_out,
    output apc_pkg::apc_route_t route_out
);

    // the field map is fixed at sixteen bits per word
    if (WORD_W != 16) begin : g_bad_width
        $error("apc_cfg_bank: WORD_W must be 16");
    end

    typedef struct packed {
        logic ss_meta;
        logic ss_sync;
        logic ss_prev;
        logic [15:0] stage_a;
        logic [15:0] stage_b;
        logic [15:0] act_a;
        logic [15:0] act_b;
        logic [15:0] rd_data;
        logic applied;
    } apc_state_t;

    apc_state_t st_r;
    apc_state_t st_nxt;
    logic ss_rise;

    // decode one word pair into routing controls
    function automatic apc_pkg::apc_route_t apc_decode(
        input logic [15:0] a,
        input logic [15:0] b
    );
        apc_pkg::apc_route_t r;
        logic [1:0] spk;
        spk = a[apc_pkg::A_SPK_LO +: 2];
        r.agc_on = ~b[apc_pkg::B_AGC_PD]; // [R1]
        r.insrc_is_agc = (a[apc_pkg::A_INSRC] == apc_pkg::INSRC_AGC); // [R2]
        r.mix1_insrc_only = (b[apc_pkg::B_MIX1_LO +: 2]
            == apc_pkg::MIX1_INSRC_ONLY); // [R3]
        // source bit high picks the array, low the first sum
        r.filt_from_array = (b[apc_pkg::B_FLTSRC]
            == apc_pkg::FLTSRC_ARRAY); // [R4] [R5]
        r.filt_on = ~b[apc_pkg::B_FLT_PD]; // [R6]
        r.rate = apc_pkg::apc_rate_t'(b[apc_pkg::B_RATE_LO +: 2]); // [R7] [R8]
        r.mix2_filt_only = (b[apc_pkg::B_MIX2_LO +: 2]
            == apc_pkg::MIX2_FILT_ONLY); // [R9]
        r.vol_from_sum2 = (b[apc_pkg::B_VSRC_LO +: 2]
            == apc_pkg::VSRC_SUM2); // [R10]
        r.vol_on = ~a[apc_pkg::A_VOL_PD]; // [R11]
        r.atten = b[apc_pkg::B_ATT_LO +: 3]; // [R12]
        r.att_is_12db = (r.atten == apc_pkg::ATT_MINUS_12DB); // [R13]
        r.spk_from_vol = (a[apc_pkg::A_OUT_LO +: 2]
            == apc_pkg::OUT_VOLUME); // [R14]
        // only the high-gain code is known to shut the aux stage off
        r.spk_high_gain = (spk == apc_pkg::SPK_HIGH_GAIN); // [R15]
        r.aux_on = ~r.spk_high_gain; // [R15]
        return r;
    endfunction : apc_decode

    // select edge comes only from the synchronised copies
    assign ss_rise = st_r.ss_sync & ~st_r.ss_prev;

    // next state: sync, stage, apply, readback
    always_comb begin
        st_nxt = st_r;
        st_nxt.ss_meta = ss_n_in;
        st_nxt.ss_sync = st_r.ss_meta;
        st_nxt.ss_prev = st_r.ss_sync;
        // staging order is the host's job; both words apply together
        if (load_in.valid && load_in.sel == apc_pkg::WSEL_A) begin
            st_nxt.stage_a = load_in.data; // [R16]
        end
        if (load_in.valid && load_in.sel == apc_pkg::WSEL_B) begin
            st_nxt.stage_b = load_in.data;
        end
        // a load in the apply cycle waits for the next frame end
        if (ss_rise) begin
            st_nxt.act_a = st_r.stage_a; // [R17]
            st_nxt.act_b = st_r.stage_b; // [R17]
        end
        st_nxt.applied = ss_rise;
        st_nxt.rd_data = (rd_sel_in == apc_pkg::WSEL_B) ?
            st_r.act_b : st_r.act_a;
    end

    // state register; unloaded words keep their values
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r.ss_meta <= 1'b1;
            st_r.ss_sync <= 1'b1;
            st_r.ss_prev <= 1'b1;
            st_r.stage_a <= apc_pkg::RST_A;
            st_r.stage_b <= apc_pkg::RST_B;
            st_r.act_a <= apc_pkg::RST_A;
            st_r.act_b <= apc_pkg::RST_B;
            st_r.rd_data <= apc_pkg::RST_A;
            st_r.applied <= 1'b0;
        end else begin
            st_r <= st_nxt; // [R18]
        end
    end

    // outputs straight from the state flops; route_out is decoded from the active words
    assign cfg_a_out = st_r.act_a;
    assign cfg_b_out = st_r.act_b;
    assign rd_data_out = st_r.rd_data;
    assign applied_out = st_r.applied;
    assign route_out = apc_decode(st_r.act_a, st_r.act_b);

    // the select rise must reach the words in exactly three edges
    property p_apply_delay;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(st_r.ss_meta) |=> ss_rise ##1
            (cfg_a_out == $past(st_r.stage_a)
            && cfg_b_out == $past(st_r.stage_b));
    endproperty
    a_apply_delay: assert property (p_apply_delay) // [R17]
        else $error("staged words not applied after select rise");

    property p_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        !ss_rise |=> $stable(cfg_a_out) && $stable(cfg_b_out);
    endproperty
    a_hold: assert property (p_hold) // [R18]
        else $error("config word changed without select rise");

    property p_stage_a;
        @(posedge clk_in) disable iff (!rst_n_in)
        (load_in.valid && load_in.sel == apc_pkg::WSEL_A)
        |=> st_r.stage_a == $past(load_in.data);
    endproperty
    a_stage_a: assert property (p_stage_a) // [R16]
        else $error("word a load lost before apply");

    property p_applied;
        @(posedge clk_in) disable iff (!rst_n_in)
        ss_rise |=> applied_out ##1 !applied_out;
    endproperty
    a_applied: assert property (p_applied) // [R17]
        else $error("apply pulse wrong");

    property p_agc;
        @(posedge clk_in) disable iff (!rst_n_in)
        ss_rise && !st_r.stage_b[apc_pkg::B_AGC_PD] |=> route_out.agc_on;
    endproperty
    a_agc: assert property (p_agc) // [R1]
        else $error("agc not powered after zero written");

    property p_insrc;
        @(posedge clk_in) disable iff (!rst_n_in)
        route_out.insrc_is_agc == !cfg_a_out[apc_pkg::A_INSRC];
    endproperty
    a_insrc: assert property (p_insrc) // [R2]
        else $error("input source select wrong");

    property p_mix1;
        @(posedge clk_in) disable iff (!rst_n_in)
        route_out.mix1_insrc_only == (cfg_b_out[8:7] == 2'h2);
    endproperty
    a_mix1: assert property (p_mix1) // [R3]
        else $error("first mix decode wrong");

    property p_fltsrc;
        @(posedge clk_in) disable iff (!rst_n_in)
        route_out.filt_from_array == cfg_b_out[4];
    endproperty
    a_fltsrc: assert property (p_fltsrc) // [R4]
        else $error("filter source decode wrong");

    property p_filt_on;
        @(posedge clk_in) disable iff (!rst_n_in)
        route_out.filt_on != cfg_b_out[1];
    endproperty
    a_filt_on: assert property (p_filt_on) // [R6]
        else $error("filter power decode wrong");

    property p_rate;
        @(posedge clk_in) disable iff (!rst_n_in)
        (cfg_b_out[3:2] == 2'h2) == (route_out.rate == apc_pkg::APC_RATE_5K3)
        && (cfg_b_out[3:2] == 2'h0)
            == (route_out.rate == apc_pkg::APC_RATE_8K0);
    endproperty
    a_rate: assert property (p_rate) // [R7] [R8]
        else $error("sample rate decode wrong");

    property p_mix2_vol;
        @(posedge clk_in) disable iff (!rst_n_in)
        route_out.mix2_filt_only == (cfg_b_out[6:5] == 2'h2)
        && route_out.vol_from_sum2 == (cfg_b_out[15:14] == 2'h1)
        && route_out.vol_on == !cfg_a_out[0];
    endproperty
    a_mix2_vol: assert property (p_mix2_vol) // [R9] [R10] [R11]
        else $error("second mix or volume decode wrong");

    property p_atten;
        @(posedge clk_in) disable iff (!rst_n_in)
        route_out.atten == cfg_b_out[13:11]
        && route_out.att_is_12db == (cfg_b_out[13:11] == 3'h3);
    endproperty
    a_atten: assert property (p_atten) // [R12] [R13]
        else $error("attenuation decode wrong");

    property p_speaker;
        @(posedge clk_in) disable iff (!rst_n_in)
        route_out.spk_from_vol == (cfg_a_out[4:3] == 2'h0)
        && (cfg_a_out[2:1] == 2'h1)
            == (route_out.spk_high_gain && !route_out.aux_on);
    endproperty
    a_speaker: assert property (p_speaker) // [R14] [R15]
        else $error("speaker routing decode wrong");

    // a word b load lands in staging on the next edge
    property p_stage_b;
        @(posedge clk_in) disable iff (!rst_n_in)
        (load_in.valid && load_in.sel == apc_pkg::WSEL_B)
        |=> st_r.stage_b == $past(load_in.data);
    endproperty
    a_stage_b: assert property (p_stage_b) // [R18]
        else $error("word b load lost in staging");

    // staged words only move on a load
    property p_stage_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        !load_in.valid |=> $stable(st_r.stage_a) && $stable(st_r.stage_b);
    endproperty
    a_stage_hold: assert property (p_stage_hold) // [R18]
        else $error("staged word changed without a load");

    // readback shows the active word picked one cycle before
    property p_readback;
        @(posedge clk_in) disable iff (!rst_n_in)
        1'h1 |=> rd_data_out == (($past(rd_sel_in) == apc_pkg::WSEL_B) ?
            $past(cfg_b_out) : $past(cfg_a_out));
    endproperty
    a_readback: assert property (p_readback) // [R18]
        else $error("readback word wrong");

    // no apply pulse without a select rise
    property p_no_apply;
        @(posedge clk_in) disable iff (!rst_n_in)
        !ss_rise |=> !applied_out;
    endproperty
    a_no_apply: assert property (p_no_apply) // [R17]
        else $error("apply pulse without select rise");

    // the pulse never stretches, so a host can count frames by it
    property p_applied_once;
        @(posedge clk_in) disable iff (!rst_n_in)
        applied_out |=> !applied_out;
    endproperty
    a_applied_once: assert property (p_applied_once) // [R17]
        else $error("apply pulse longer than one cycle");

    // every apply pulse shows both staged words at once
    property p_apply_pair;
        @(posedge clk_in) disable iff (!rst_n_in)
        applied_out |-> cfg_a_out == $past(st_r.stage_a)
            && cfg_b_out == $past(st_r.stage_b);
    endproperty
    a_apply_pair: assert property (p_apply_pair) // [R17]
        else $error("words not applied together");

    // analog controls must not glitch between frame ends
    property p_route_steady;
        @(posedge clk_in) disable iff (!rst_n_in)
        !ss_rise |=> $stable(route_out);
    endproperty
    a_route_steady: assert property (p_route_steady) // [R17]
        else $error("routing changed without select rise");

    // source bit high must take the array playback path
    property p_filt_array;
        @(posedge clk_in) disable iff (!rst_n_in)
        cfg_b_out[apc_pkg::B_FLTSRC] |-> route_out.filt_from_array;
    endproperty
    a_filt_array: assert property (p_filt_array) // [R5]
        else $error("filter not fed from array playback");

endmodule : apc_cfg_bank

// ### apc_host_model.sv
// host side model: loads config words in frames under slave select
`timescale 1ns/1ps
module apc_host_model (
    input wire logic clk_in,
    output apc_pkg::apc_load_t load_out,
    output logic ss_n_out
);
    initial begin
        load_out = '{valid: 1'b0, sel: 1'b0, data: 16'h0000};
        ss_n_out = 1'b1;
    end
    // one word per valid pulse; idle data inverted so stale data never passes
    task automatic load_word(input logic sel, input logic [15:0] d);
        @(posedge clk_in);
        load_out <= '{valid: 1'b1, sel: sel, data: d};
        @(posedge clk_in);
        load_out <= '{valid: 1'b0, sel: sel, data: ~d};
    endtask : load_word
    // select low, word a if do_a then word b, select high applies both
    task automatic frame(input logic do_a, input logic [15:0] a,
        input logic [15:0] b);
        @(posedge clk_in);
        ss_n_out <= 1'b0;
        if (do_a) load_word(apc_pkg::WSEL_A, a);
        load_word(apc_pkg::WSEL_B, b);
        @(posedge clk_in);
        ss_n_out <= 1'b1;
    endtask : frame
endmodule : apc_host_model

// ### testbench.sv
// self-checking bench for the audio path config bank
`timescale 1ns/1ps
module testbench;
    logic clk_in;
    logic rst_n_in;
    logic rd_sel_in;
    apc_pkg::apc_load_t load_w;
    logic ss_n_w;
    logic [15:0] rd_data_out;
    logic [15:0] cfg_a_out;
    logic [15:0] cfg_b_out;
    logic applied_out;
    apc_pkg::apc_route_t route_out;
    int n_errors = 0;
    int cmp_count = 0;
    integer seed = 32'hb320;
    logic [15:0] a_exp;
    logic [15:0] b_exp;
    logic [15:0] rnd;

    apc_cfg_bank i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ss_n_in(ss_n_w), .load_in(load_w), .rd_sel_in(rd_sel_in),
        .rd_data_out(rd_data_out), .cfg_a_out(cfg_a_out),
        .cfg_b_out(cfg_b_out), .applied_out(applied_out),
        .route_out(route_out));
    apc_host_model i_host (.clk_in(clk_in), .load_out(load_w),
        .ss_n_out(ss_n_w));

    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // decode expected from the field layout of both words
    function automatic apc_pkg::apc_route_t exp_route(
        input logic [15:0] a, input logic [15:0] b);
        apc_pkg::apc_route_t r;
        r.agc_on = ~b[0];
        r.insrc_is_agc = ~a[9];
        r.mix1_insrc_only = (b[8:7] == 2'h2);
        r.filt_from_array = b[4];
        r.filt_on = ~b[1];
        r.rate = apc_pkg::apc_rate_t'(b[3:2]);
        r.mix2_filt_only = (b[6:5] == 2'h2);
        r.vol_from_sum2 = (b[15:14] == 2'h1);
        r.vol_on = ~a[0];
        r.atten = b[13:11];
        r.att_is_12db = (b[13:11] == 3'h3);
        r.spk_from_vol = (a[4:3] == 2'h0);
        r.spk_high_gain = (a[2:1] == 2'h1);
        r.aux_on = (a[2:1] != 2'h1);
        return r;
    endfunction : exp_route

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
        end
    endtask : cmp16

    task automatic cmp_route(input apc_pkg::apc_route_t got,
        input apc_pkg::apc_route_t exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: route %h want %h", $time, got, exp);
        end
    endtask : cmp_route

    task automatic test_done;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // one frame, then a bounded wait for the apply pulse
    task automatic run_frame(input logic do_a, input logic [15:0] a,
        input logic [15:0] b);
        int k;
        i_host.frame(do_a, a, b);
        if (do_a) a_exp = a;
        b_exp = b;
        k = 0;
        while (applied_out !== 1'b1 && k < 20) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        cmp16({15'h0000, applied_out}, 16'h0001);
        cmp16(cfg_a_out, a_exp);
        cmp16(cfg_b_out, b_exp);
        cmp_route(route_out, exp_route(a_exp, b_exp));
        @(posedge clk_in);
        #1;
        cmp16({15'h0000, applied_out}, 16'h0000);
    endtask : run_frame

    task automatic rd_chk(input logic sel, input logic [15:0] exp);
        @(posedge clk_in);
        rd_sel_in <= sel;
        @(posedge clk_in);
        #1;
        cmp16(rd_data_out, exp);
    endtask : rd_chk

    // hang guard, far beyond the roughly 150 cycles the run needs
    initial begin
        #200000;
        n_errors++;
        test_done();
    end

    initial begin
        rst_n_in = 1'b0;
        rd_sel_in = 1'b0;
        a_exp = apc_pkg::RST_A;
        b_exp = apc_pkg::RST_B;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        cmp16(cfg_a_out, apc_pkg::RST_A);
        cmp16(cfg_b_out, apc_pkg::RST_B);
        // memo record, then playback
        run_frame(1'b1, 16'h2421, 16'h0148);
        cmp16({14'h0000, route_out.rate}, 16'h0002);
        run_frame(1'b1, 16'h2422, 16'h59D1);
        cmp_route(route_out, exp_route(16'h2422, 16'h59D1));
        cmp16({13'h0000, route_out.att_is_12db, route_out.spk_high_gain,
            route_out.aux_on}, 16'h0006);
        // a load with no frame end must stay staged
        i_host.load_word(apc_pkg::WSEL_B, 16'h1234);
        repeat (6) @(posedge clk_in);
        #1;
        cmp16(cfg_b_out, 16'h59D1);
        rd_chk(1'b1, 16'h59D1);
        rd_chk(1'b0, 16'h2422);
        run_frame(1'b0, 16'h0000, 16'h00C5);
        // random words, sweeping every attenuation step
        for (int i = 0; i < 8; i++) begin
            rnd = 16'($random(seed));
            rnd[13:11] = 3'(i);
            run_frame(1'b1, 16'($random(seed)), rnd);
            rd_chk(rnd[0], rnd[0] ? b_exp : a_exp);
        end
        test_done();
    end
endmodule : testbench
